//--- design/tsh_top.sv
// Test start handshake: start contact, table latch, phase timing and result contacts.
// Assumes inputs synchronous to clk_i; the measurement core supplies volts and results.
//
// Operation
// - Start is recognised about 1 ms after contact turns ON.
// - Table switching takes about 10 ms before trigger delay.
// - Lower new test voltage adds a discharge interval to switching.
// - Pulse application and sampling lasts about 50 ms.
// - Computation and judgment lasts about 15 ms.
// - Multi-pulse judgment phase covers only the last pulse.
// - Judgment outputs settle before end-of-measurement asserts.
// - Start ignored while end-of-measurement is OFF.
// - Sourcing setting: terminal level equals logical state.
// - Sinking setting: terminal level is inverse of logical state.
// - Table selection latched at start, switched before testing.
// - Sampling-complete asserts when pulse application and sampling finish.
// - Judgment and error outputs update one cycle before end-of-measurement asserts.
// - Test begins on start OFF-to-ON transition, not level.
`default_nettype none
module tsh_top
    import tsh_pkg::*;
#(
    parameter int unsigned MS_TICK   = tsh_pkg::MS_TICK_CYC,
    parameter int unsigned SWITCH_MS = tsh_pkg::TABLE_SWITCH_MS,
    parameter int unsigned DISCH_MS  = tsh_pkg::DISCHARGE_MS,
    parameter int unsigned SAMP_MS   = tsh_pkg::SAMPLE_MS,
    parameter int unsigned JUDG_MS   = tsh_pkg::JUDGE_MS
)(
    input  wire logic               clk_i,            // 100 MHz clock
    input  wire logic               rst_n_i,          // Async reset, active low
    input  wire logic               sourcing_i,       // 1 sourcing, 0 sinking contacts
    input  wire logic               start_term_i,     // Start terminal level
    input  wire logic [7:0]         table_term_i,     // Table selection terminal levels
    input  wire logic [13:0]        trig_delay_ms_i,  // Trigger delay in ms
    input  wire logic [15:0]        table_volt_i,     // Test voltage of selected table
    input  wire tsh_pkg::tsh_judge_t judge_i,         // Results from measurement core
    output logic [7:0]              table_sel_o,      // Latched table number
    output logic                    table_load_o,     // Pulse: load table now
    output logic                    pulse_run_o,      // Level: pulse and sampling phase
    output logic                    index_term_o,     // Sampling-complete terminal level
    output logic                    done_term_o,      // End-of-measurement terminal level
    output tsh_pkg::tsh_judge_t     judge_term_o      // Result terminal levels
);
    import tsh_pkg::*;

    tsh_state_t             state;
    tsh_state_t             next_state;
    logic [MS_CNT_W-1:0]    tick_cnt;
    logic [PHASE_CNT_W-1:0] ms_cnt;
    logic                   start_prev;
    logic [7:0]             table_sel;
    logic [15:0]            prev_volt;
    logic                   index_on;
    logic                   done_on;
    tsh_judge_t             judge_q;

    // Contact polarity applied at the boundary only
    wire        start_on   = sourcing_i ? start_term_i : ~start_term_i;
    wire [7:0]  table_on   = sourcing_i ? table_term_i : ~table_term_i;
    wire        start_rise = start_on & ~start_prev;
    wire        ms_tick    = (tick_cnt == MS_CNT_W'(MS_TICK - 1));
    wire        volt_drop  = (table_volt_i < prev_volt);
    wire [PHASE_CNT_W-1:0] switch_len = volt_drop ?
                           PHASE_CNT_W'(SWITCH_MS + DISCH_MS) : PHASE_CNT_W'(SWITCH_MS);
    wire [13:0] delay_ms   = (trig_delay_ms_i > 14'(DELAY_MAX_MS)) ? 14'(DELAY_MAX_MS) : trig_delay_ms_i;
    wire        phase_end  = ms_tick & (ms_cnt == '0);

    always_comb
    begin
        next_state = state;
        unique case (state)
            TSH_IDLE:   if (start_rise && done_on) next_state = TSH_DETECT;
            TSH_DETECT: if (phase_end) next_state = TSH_SWITCH;
            TSH_SWITCH: if (phase_end) next_state = TSH_DELAY;
            TSH_DELAY:  if (phase_end || ms_cnt == '0 && delay_ms == '0) next_state = TSH_SAMPLE;
            TSH_SAMPLE: if (phase_end) next_state = TSH_JUDGE;
            TSH_JUDGE:  if (phase_end) next_state = TSH_IDLE;
            default:    next_state = TSH_IDLE;
        endcase
    end

    // Millisecond divider restarts per phase so each phase length is exact
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            tick_cnt <= '0;
        else if (next_state != state || ms_tick)
            tick_cnt <= '0;
        else
            tick_cnt <= tick_cnt + MS_CNT_W'(1);
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            ms_cnt <= '0;
        else if (next_state != state)
        begin
            unique case (next_state)
                TSH_DETECT: ms_cnt <= PHASE_CNT_W'(DETECT_MS - 1);
                TSH_SWITCH: ms_cnt <= switch_len - PHASE_CNT_W'(1);
                TSH_DELAY:  ms_cnt <= (delay_ms == '0) ? '0 : delay_ms - 14'd1;
                TSH_SAMPLE: ms_cnt <= PHASE_CNT_W'(SAMP_MS - 1);
                TSH_JUDGE:  ms_cnt <= PHASE_CNT_W'(JUDG_MS - 1);
                default:    ms_cnt <= '0;
            endcase
        end
        else if (ms_tick && ms_cnt != '0)
            ms_cnt <= ms_cnt - PHASE_CNT_W'(1);
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state      <= TSH_IDLE;
            start_prev <= 1'b0;
            table_sel  <= TABLE_RESET;
            prev_volt  <= VOLT_RESET;
            index_on   <= 1'b0;
            done_on    <= 1'b1;
            judge_q    <= '0;
        end
        else
        begin
            state      <= next_state;
            start_prev <= start_on;
            // Done contact still OFF in the first idle cycle, so starts there are refused
            if (state == TSH_IDLE && start_rise && done_on)
            begin
                table_sel <= table_on;
                done_on   <= 1'b0;
                index_on  <= 1'b0;
            end
            if (state == TSH_SWITCH && next_state == TSH_DELAY)
                prev_volt <= table_volt_i;
            if (state == TSH_SAMPLE && next_state == TSH_JUDGE)
                index_on <= 1'b1;
            // Results land one cycle ahead of the done contact
            if (state == TSH_JUDGE && next_state == TSH_IDLE)
                judge_q <= judge_i;
            if (state == TSH_IDLE && done_on == 1'b0)
                done_on <= 1'b1;
        end
    end

    assign table_sel_o  = table_sel;
    assign table_load_o = (state == TSH_DETECT) && phase_end;
    assign pulse_run_o  = (state == TSH_SAMPLE);
    assign index_term_o = sourcing_i ? index_on : ~index_on;
    assign done_term_o  = sourcing_i ? done_on : ~done_on;
    assign judge_term_o = sourcing_i ? judge_q : ~judge_q;
endmodule
`default_nettype wire

//--- design/tsh_pkg.sv
// Package for the test start handshake block: timing constants and carriers.
// Assumes a single 100 MHz clock; all times are counted in clk_i cycles.
`default_nettype none
package tsh_pkg;
    localparam int unsigned CLK_HZ          = 100_000_000;
    localparam int unsigned CYC_PER_MS      = CLK_HZ / 1000;
    localparam int unsigned DETECT_MS       = 1;
    localparam int unsigned TABLE_SWITCH_MS = 10;
    localparam int unsigned DISCHARGE_MS    = 20;
    localparam int unsigned SAMPLE_MS       = 50;
    localparam int unsigned JUDGE_MS        = 15;
    localparam int unsigned DELAY_MAX_MS    = 9999;
    localparam int unsigned MS_TICK_CYC     = CYC_PER_MS;
    localparam int unsigned MS_CNT_W        = 17;
    localparam int unsigned PHASE_CNT_W     = 14;

    localparam logic [7:0] TABLE_RESET      = 8'h00;
    localparam logic [15:0] VOLT_RESET      = 16'h0000;

    // Judgment result bundle as seen at the contacts
    typedef struct packed {
        logic       pass;
        logic       fail;
        logic [3:0] out_fn;
        logic       err;
    } tsh_judge_t;

    typedef enum logic [2:0] {
        TSH_IDLE   = 3'b000,
        TSH_DETECT = 3'b001,
        TSH_SWITCH = 3'b011,
        TSH_DELAY  = 3'b010,
        TSH_SAMPLE = 3'b110,
        TSH_JUDGE  = 3'b111
    } tsh_state_t;
endpackage
`default_nettype wire

//--- dv/tsh_top_asserts.sv
// Checker for the start handshake: phase order and contact timing at the ports.
// Assumes the bench runs MS_TICK 4 with 2 ms sampling and judging.
`default_nettype none
module tsh_top_asserts
    import tsh_pkg::*;
#(parameter int unsigned MS_TICK = tsh_pkg::MS_TICK_CYC)(
    input wire logic clk_i, rst_n_i, sourcing_i, start_term_i, table_load_o, pulse_run_o,
    input wire logic index_term_o, done_term_o,
    input wire logic [7:0] table_term_i, table_sel_o,
    input wire logic [13:0] trig_delay_ms_i,
    input wire logic [15:0] table_volt_i,
    input wire tsh_pkg::tsh_judge_t judge_i, judge_term_o
);
    localparam int LD = MS_TICK - 1;
    wire logic st = start_term_i ^ ~sourcing_i;
    wire logic dn = done_term_o ^ ~sourcing_i;
    wire logic ix = index_term_o ^ ~sourcing_i;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    AST_ACCEPT: assert property (st && !$past(st) && dn |=> !dn) else $error("start edge not taken");
    AST_LOAD: assert property ($fell(dn) |-> ##[LD:LD] table_load_o) else $error("load late");
    AST_LATCH: assert property (!dn && !$fell(dn) |-> $stable(table_sel_o)) else $error("table moved");
    // Eight cycles: 2 ms at the bench tick
    AST_SAMP: assert property ($rose(pulse_run_o) |-> pulse_run_o[*8] ##1 !pulse_run_o) else $error("sample len");
    AST_INDEX: assert property ($fell(pulse_run_o) |-> ix) else $error("index missing");
    AST_IXCLR: assert property ($fell(dn) |-> !ix) else $error("index kept");
    AST_JUDGE: assert property ($fell(pulse_run_o) |-> !dn[*8] ##[1:2] dn) else $error("judge len");
    AST_ORDER: assert property ($rose(dn) |-> $stable(judge_term_o) && !pulse_run_o) else $error("late result");
    AST_HOLD: assert property (dn && $past(dn) |-> $stable(judge_term_o)) else $error("result moved");
    cover property ($rose(dn));
    cover property ($rose(ix));
    cover property ($fell(dn) && !sourcing_i);
endmodule
bind tsh_top tsh_top_asserts #(.MS_TICK(MS_TICK)) u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .sourcing_i(sourcing_i), .start_term_i(start_term_i), .table_load_o(table_load_o),
    .pulse_run_o(pulse_run_o), .index_term_o(index_term_o), .done_term_o(done_term_o),
    .table_term_i(table_term_i), .table_sel_o(table_sel_o), .trig_delay_ms_i(trig_delay_ms_i),
    .table_volt_i(table_volt_i), .judge_i(judge_i), .judge_term_o(judge_term_o));
`default_nettype wire

//--- dv/tsh_ctrl_model.sv
// Controller model: maps logical requests to contact levels in either polarity.
// Assumes the bench decides when start rises and how long it is held.
`default_nettype none
module tsh_ctrl_model (
    input  wire logic       sourcing_i,   // 1 sourcing
    input  wire logic       on_i,         // Logical start
    input  wire logic [7:0] tbl_i,        // Logical table
    input  wire logic       done_term_i,  // Done terminal
    output logic            start_term_o, // Start terminal
    output logic [7:0]      table_term_o, // Table terminals
    output logic            done_o        // Logical done
);
    timeunit 1ns;
    timeprecision 1ps;
    assign start_term_o = on_i ^ ~sourcing_i;
    assign table_term_o = tbl_i ^ {8{~sourcing_i}};
    assign done_o = done_term_i ^ ~sourcing_i;
endmodule
`default_nettype wire

//--- dv/tb_test_start_handshake.sv
// Bench for the start handshake: timed tests through the controller model.
// Assumes shortened phase parameters; durations compared as differences.
`default_nettype none
module tb_test_start_handshake;
    timeunit 1ns;
    timeprecision 1ps;
    import tsh_pkg::*;
    localparam int TK = 4;
    logic clk_i = 0, rst_n_i = 0, sourcing_i = 1, on = 0, done, st, ld, pr, ix, dt;
    logic [7:0] tbl = 0, tt, sel;
    logic [13:0] dly = 0;
    logic [15:0] volt = 0;
    tsh_judge_t jin = '0, jout;
    int num_errors = 0, samples_checked = 0, d0, d1;
    initial forever #5 clk_i = ~clk_i;
    tsh_ctrl_model u_ctrl (.sourcing_i(sourcing_i), .on_i(on), .tbl_i(tbl), .done_term_i(dt),
        .start_term_o(st), .table_term_o(tt), .done_o(done));
    tsh_top #(.MS_TICK(TK), .SWITCH_MS(2), .DISCH_MS(3), .SAMP_MS(2), .JUDG_MS(2)) uut (.clk_i(clk_i),
        .rst_n_i(rst_n_i), .sourcing_i(sourcing_i), .start_term_i(st), .table_term_i(tt),
        .trig_delay_ms_i(dly), .table_volt_i(volt), .judge_i(jin), .table_sel_o(sel),
        .table_load_o(ld), .pulse_run_o(pr), .index_term_o(ix), .done_term_o(dt), .judge_term_o(jout));
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        samples_checked++;
        if (g !== e)
        begin
            num_errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Mode 1 retriggers mid-test with another table, mode 2 holds start on
    task automatic run(input logic [7:0] t, input logic [15:0] v, input logic [13:0] d, input int m,
                       output int n);
        @(negedge clk_i);
        on = 1; tbl = t; volt = v; dly = d; jin = tsh_judge_t'(t[6:0]);
        n = 0;
        while (n < 400 && (n < 3 || done !== 1'b1))
        begin
            @(negedge clk_i);
            n++;
            if (n == 2) chk(done, 0);
            if (n == 6 && m != 2) on = 0;
            if (m == 1 && n == 20) begin on = 1; tbl = ~t; end
            if (m == 1 && n == 26) on = 0;
        end
        if (n >= 400)
        begin
            num_errors++;
            $display("MISMATCH t=%0t done never returned", $time);
        end
        @(negedge clk_i);
        chk(sel, t);
        chk(jout, t[6:0] ^ {7{~sourcing_i}});
        $display("test table %h took %0d", t, n);
    endtask
    task automatic t_disch(); run(8'hA5, 16'h0032, 0, 0, d1); chk(d1, d0 + 3 * TK); endtask
    task automatic t_delay(); run(8'h80, 16'h0032, 3, 0, d1); chk(d1, d0 + 3 * TK - 1); endtask
    task automatic t_ignore(); run(8'h3C, 16'h0032, 0, 1, d1); chk(d1, d0); endtask
    task automatic t_level();
        run(8'hFF, 16'h0032, 0, 2, d1);
        repeat (20) @(negedge clk_i);
        chk(done, 1);
        on = 0;
    endtask
    task automatic t_sink();
        rst_n_i = 0; sourcing_i = 0;
        repeat (2) @(negedge clk_i);
        rst_n_i = 1;
        run(8'h5A, 16'h0064, 0, 0, d1); chk(d1, d0);
    endtask
    initial
    begin
        repeat (4) @(negedge clk_i);
        rst_n_i = 1;
        run(8'h01, 16'h0064, 0, 0, d0);
        t_disch(); t_delay(); t_ignore(); t_level(); t_sink();
        tally_and_finish();
    end
endmodule
`default_nettype wire
